// file: rtl/otpps_map.svh
`ifndef OTPPS_MAP_SVH
`define OTPPS_MAP_SVH

// Clock rate of mclk in MHz.
`define OTPPS_CLK_MHZ 50
// Nominal program pulse width in ns (50 us).
`define OTPPS_PULSE_NS 50000
// Allowed pulse window in ns.
`define OTPPS_PULSE_MIN_NS 47500
`define OTPPS_PULSE_MAX_NS 52500
// Pulse width in cycles, derived from the nominal time.
`define OTPPS_PULSE_CYC ((`OTPPS_PULSE_NS * `OTPPS_CLK_MHZ) / 1000)
// Generic setup/hold/recovery gap in ns (2 us), rounded up to cycles.
`define OTPPS_GAP_NS 2000
`define OTPPS_GAP_CYC ((`OTPPS_GAP_NS * `OTPPS_CLK_MHZ + 999) / 1000)
// Read access wait in ns (150 ns), rounded up to cycles.
`define OTPPS_RD_NS 150
`define OTPPS_RD_CYC ((`OTPPS_RD_NS * `OTPPS_CLK_MHZ + 999) / 1000)
// Retry pulses allowed per byte.
`define OTPPS_RETRY_MAX 10
// Address bit that selects the device-type code in identification mode.
`define OTPPS_ID_SEL_BIT 8

`endif

// file: rtl/otpps_pkg.sv
package otpps_pkg;

	// Sequencer states.
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0000,
		ST_PWRUP  = 4'b0001,
		ST_ADDR   = 4'b0010,
		ST_LATCH  = 4'b0011,
		ST_DATA   = 4'b0100,
		ST_PULSE  = 4'b0101,
		ST_RECOV  = 4'b0110,
		ST_VREAD  = 4'b0111,
		ST_VCHECK = 4'b1000,
		ST_PWRDN  = 4'b1001,
		ST_DONE   = 4'b1010
	} otpps_state_t;

	// Programming pass in progress.
	typedef enum logic [1:0] {
		PH_BLIND  = 2'b00,
		PH_VERIFY = 2'b01,
		PH_FINAL  = 2'b10
	} otpps_phase_t;

	// Supply and pin controls towards the device.
	typedef struct packed {
		logic vccHigh;
		logic vccOn;
		logic vppHigh;
		logic oeLowN;
		logic latchStrobe;
	} otpps_pins_t;

	// Result reported to the host.
	typedef struct packed {
		logic busy;
		logic done;
		logic pass;
		logic retryFail;
		logic [15:0] failAddr;
	} otpps_status_t;

endpackage : otpps_pkg

// file: rtl/otpps_image_mem.sv
// Source image store; the read word comes out of a register.
module otpps_image_mem #(
	parameter int AW = 16
) (
	input  wire logic          mclk,
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [7:0]    wrData,
	input  wire logic [AW-1:0] rdAddr,
	output logic      [7:0]    rdData
);

	// Storage array, no reset so it maps to block memory.
	logic [7:0] memArray [0:(1<<AW)-1];

	// Synchronous write and registered read.
	always_ff @(posedge mclk)
	begin
		if (wrEn)
		begin
			memArray[wrAddr] <= wrData;
		end
		rdData <= memArray[rdAddr];
	end

endmodule : otpps_image_mem

// file: rtl/otpps_sequencer.sv
// Summary of operation
// - Program each byte with 50 us strobe.
// - Pulse width within 47.5 to 52.5 us.
// - Start programming at the first address.
// - Raise supply to 6.5V, program pin 13V.
// - Supply up first, down last.
// - First pass: one pulse each, no verify.
// - Then verify-and-reprogram loop per address.
// - Failing byte: up to 10 pulses, verifying.
// - Still failing after 10: device failed.
// - Verified byte advances until all checked.
// - Drop voltages, read back, compare all; the code ends the run at the first mismatching byte.
`include "otpps_map.svh"

module otpps_sequencer #(
	parameter int AW        = 16,
	parameter int PULSE_CYC = `OTPPS_PULSE_CYC,
	parameter int GAP_CYC   = `OTPPS_GAP_CYC,
	parameter int RETRIES   = `OTPPS_RETRY_MAX
) (
	input  wire logic                  mclk,
	input  wire logic                  rstn,
	input  wire logic                  imgWrEn,
	input  wire logic [AW-1:0]         imgWrAddr,
	input  wire logic [7:0]            imgWrData,
	input  wire logic                  startProg,
	input  wire logic                  startId,
	input  wire logic [AW-1:0]         lastAddr,
	output otpps_pkg::otpps_status_t   status,
	output logic [15:0]                idCodes,
	output otpps_pkg::otpps_pins_t     pins,
	output logic [AW-9:0]              address_bit_eight,
	input  wire logic [7:0]            muxed_addr_data_lines_in,
	output logic [7:0]                 muxed_addr_data_lines_out,
	output logic                       muxed_addr_data_lines_oe
);
	import otpps_pkg::*;

	localparam int CW = 32;

	// Control state.
	otpps_state_t    state_reg, state_next;
	otpps_phase_t    phase_reg;
	logic [AW-1:0]   addr_reg;
	logic [CW-1:0]   cnt_reg;
	logic [3:0]      retry_reg;
	logic            idMode_reg;
	logic            idHigh_reg;
	otpps_status_t   status_reg;
	logic            passPend_reg; // Verdict held back until the run has ended.
	otpps_pins_t     pins_reg;
	logic [15:0]     id_reg;
	logic [7:0]      busOut_reg;
	logic            busOe_reg;
	logic [7:0]      imgData;

	// Image store for the source data.
	otpps_image_mem #(.AW(AW)) u_mem (
		.mclk   (mclk),
		.wrEn   (imgWrEn),
		.wrAddr (imgWrAddr),
		.wrData (imgWrData),
		.rdAddr (addr_reg),
		.rdData (imgData)
	);

	// Wait-count expiry and decode wires.
	wire timerDone = (cnt_reg == '0);
	wire lastByte  = (addr_reg == lastAddr);
	wire byteOk    = (muxed_addr_data_lines_in == imgData);
	wire retryOut  = (retry_reg == 4'(RETRIES));
	wire readOnly   = idMode_reg || (phase_reg == PH_FINAL) || (phase_reg == PH_VERIFY && retry_reg == 4'h0);
	wire advance    = !idMode_reg && (phase_reg == PH_BLIND || byteOk);
	wire retryLimit = !idMode_reg && (phase_reg == PH_VERIFY) && !byteOk && retryOut;
	wire finalBad   = !idMode_reg && (phase_reg == PH_FINAL) && !byteOk;
	wire passNow    = idMode_reg ? idHigh_reg : (phase_reg == PH_FINAL && byteOk && lastByte);
	// Any of these ends the run; otherwise the next address or retry goes out.
	wire runEnd     = retryLimit || finalBad || passNow;

	// Loads the wait counter with a cycle count less one.
	function automatic logic [CW-1:0] waitLoad(input int cyc);
		waitLoad = CW'(cyc - 1);
	endfunction : waitLoad

	assign status = status_reg;
	assign pins = pins_reg;
	assign idCodes = id_reg;
	assign address_bit_eight = idMode_reg ? {{(AW-9){1'b0}}, idHigh_reg} : addr_reg[AW-1:8];
	assign muxed_addr_data_lines_out = busOut_reg;
	assign muxed_addr_data_lines_oe = busOe_reg;

	// Next-state decode; each wait state runs until its counter expires.
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:   state_next = (startProg | startId) ? ST_PWRUP : ST_IDLE;
			ST_PWRUP:  state_next = timerDone ? ST_ADDR : ST_PWRUP;
			ST_ADDR:   state_next = timerDone ? ST_LATCH : ST_ADDR;
			ST_LATCH:  state_next = timerDone ? (readOnly ? ST_VREAD : ST_DATA) : ST_LATCH;
			ST_DATA:   state_next = timerDone ? ST_PULSE : ST_DATA;
			ST_PULSE:  state_next = timerDone ? ST_RECOV : ST_PULSE;
			ST_RECOV:  state_next = timerDone ? ((phase_reg == PH_BLIND) ? ST_VCHECK : ST_VREAD) : ST_RECOV;
			ST_VREAD:  state_next = timerDone ? ST_VCHECK : ST_VREAD;
			ST_VCHECK: state_next = runEnd ? ST_PWRDN : ST_PWRUP;
			ST_PWRDN:  state_next = timerDone ? ST_DONE : ST_PWRDN;
			ST_DONE:   state_next = ST_IDLE;
			default:   state_next = ST_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= ST_IDLE;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Datapath: counters, pins and results. One block keeps the sequence readable.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			phase_reg  <= PH_BLIND;
			addr_reg   <= '0;
			cnt_reg    <= '0;
			retry_reg  <= 4'h0;
			idMode_reg <= 1'b0;
			idHigh_reg <= 1'b0;
			status_reg <= '0;
			passPend_reg <= 1'b0;
			pins_reg   <= '0;
			id_reg     <= 16'h0000;
			busOut_reg <= 8'h00;
			busOe_reg  <= 1'b0;
		end
		else
		begin
			if (!timerDone)
			begin
				cnt_reg <= cnt_reg - 1'b1;
			end
			case (state_reg)
				ST_IDLE:
				begin
					if (startProg | startId)
					begin
						addr_reg   <= '0;
						phase_reg  <= PH_BLIND;
						retry_reg  <= 4'h0;
						idMode_reg <= startId;
						idHigh_reg <= 1'b0;
						status_reg <= '0;
						status_reg.busy <= 1'b1;
						passPend_reg    <= 1'b0;
						pins_reg.vccOn   <= 1'b1;
						pins_reg.vccHigh <= startProg;
						pins_reg.oeLowN  <= 1'b1;
						cnt_reg <= waitLoad(GAP_CYC);
					end
				end
				ST_PWRUP:
				begin
					// Address goes out with the strobe high, ready to latch.
					if (timerDone)
					begin
						busOut_reg <= addr_reg[7:0];
						busOe_reg  <= 1'b1;
						pins_reg.latchStrobe <= 1'b1;
						pins_reg.oeLowN <= 1'b1;
						cnt_reg <= waitLoad(GAP_CYC);
					end
				end
				ST_ADDR:
				begin
					if (timerDone)
					begin
						pins_reg.latchStrobe <= 1'b0;
						cnt_reg <= waitLoad(GAP_CYC);
					end
				end
				ST_LATCH:
				begin
					if (timerDone)
					begin
						// Program voltage raised.
						// A read instead releases the bus and enables the part's outputs.
						busOut_reg       <= imgData;
						busOe_reg        <= !readOnly;
						pins_reg.oeLowN  <= !readOnly;
						pins_reg.vppHigh <= !readOnly;
						cnt_reg <= waitLoad(GAP_CYC);
					end
				end
				ST_DATA:
				begin
					if (timerDone)
					begin
						pins_reg.latchStrobe <= 1'b1;
						cnt_reg <= waitLoad(PULSE_CYC);
					end
				end
				ST_PULSE:
				begin
					if (timerDone)
					begin
						pins_reg.latchStrobe <= 1'b0;
						cnt_reg <= waitLoad(GAP_CYC);
					end
				end
				ST_RECOV:
				begin
					if (timerDone)
					begin
						// Program voltage leaves; a verify read follows outside the blind pass.
						pins_reg.vppHigh <= 1'b0;
						busOe_reg        <= (phase_reg == PH_BLIND);
						pins_reg.oeLowN  <= (phase_reg == PH_BLIND);
						cnt_reg <= waitLoad(GAP_CYC);
					end
				end
				ST_VCHECK:
				begin
					// Outputs are shut only after this sample, so the read word is still driven here.
					pins_reg.oeLowN <= 1'b1;
					cnt_reg <= waitLoad(GAP_CYC);
					passPend_reg <= passNow;
					if (idMode_reg)
					begin
						idHigh_reg <= 1'b1;
						if (idHigh_reg)
							id_reg[7:0] <= muxed_addr_data_lines_in;
						else
							id_reg[15:8] <= muxed_addr_data_lines_in;
					end
					else if (advance)
					begin
						retry_reg <= 4'h0;
						addr_reg  <= lastByte ? '0 : addr_reg + 1'b1;
						if (lastByte && phase_reg == PH_BLIND)
							phase_reg <= PH_VERIFY;
						if (lastByte && phase_reg == PH_VERIFY)
						begin
							pins_reg.vccHigh <= 1'b0;
							phase_reg        <= PH_FINAL;
						end
					end
					else if (phase_reg == PH_VERIFY && !retryOut)
						retry_reg <= retry_reg + 1'b1;
					if (retryLimit)
						status_reg.retryFail <= 1'b1;
					// Limitation: the first bad byte ends the run, so later bytes stay unchecked.
					if (retryLimit || finalBad)
						status_reg.failAddr <= 16'(addr_reg);
				end
				ST_PWRDN:
				begin
					busOe_reg <= 1'b0;
					pins_reg.vppHigh <= 1'b0;
					pins_reg.latchStrobe <= 1'b0;
					pins_reg.oeLowN <= 1'b1;
					if (timerDone)
					begin
						pins_reg.vccOn   <= 1'b0;
						pins_reg.vccHigh <= 1'b0;
					end
				end
				ST_DONE:
				begin
					status_reg.busy <= 1'b0;
					status_reg.done <= 1'b1;
					status_reg.pass <= passPend_reg;
				end
				default:
				begin
					busOe_reg <= 1'b0;
				end
			endcase
		end
	end

endmodule : otpps_sequencer

// file: testbench/otpps_sequencer_properties.sv
`include "otpps_map.svh"

// Watches the controller pins for supply, pulse and result ordering.
module otpps_seq_chk #(
	parameter int AW        = 16
) (
	input wire logic                     mclk,
	input wire logic                     rstn,
	input wire otpps_pkg::otpps_status_t status,
	input wire otpps_pkg::otpps_pins_t   pins,
	input wire logic [AW-9:0]            address_bit_eight,
	input wire logic                     muxed_addr_data_lines_oe
);
	import otpps_pkg::*;
	// Pulse window in cycles, taken from the time limits rather than the design's own count.
	localparam int PW_MIN = `OTPPS_PULSE_MIN_NS * `OTPPS_CLK_MHZ / 1000;
	localparam int PW_MAX = `OTPPS_PULSE_MAX_NS * `OTPPS_CLK_MHZ / 1000;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	// Cycles the current high-voltage strobe has stood.
	int pwCnt;

	// Counting here avoids a long repetition the tools would unroll.
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			pwCnt <= 0;
		else
			pwCnt <= (pins.latchStrobe && pins.vppHigh) ? pwCnt + 1 : 0;

	// End of a program pulse.
	sequence sPulseEnd;
		$fell(pins.latchStrobe) && $past(pins.vppHigh);
	endsequence
	// Start of any run.
	sequence sRun;
		$rose(status.busy);
	endsequence

	a_pulse_width_ok: assert property (
		sPulseEnd |-> pwCnt >= PW_MIN && pwCnt <= PW_MAX)
		else $error("program pulse width out of window");
	a_vpp_spans_pulse: assert property (
		$fell(pins.vppHigh) |-> !$past(pins.latchStrobe))
		else $error("program voltage dropped inside a pulse");
	a_vcc_under_vpp: assert property (
		pins.vppHigh |-> pins.vccOn)
		else $error("program voltage without core supply");
	a_vpp_high_vcc: assert property (
		pins.vppHigh |-> pins.vccHigh)
		else $error("program voltage at normal supply");
	a_run_first_addr: assert property (
		sRun |-> ##[0:8] address_bit_eight == '0)
		else $error("run did not begin at first address");
	a_pass_after_done: assert property (
		status.pass |-> status.done)
		else $error("pass without done");
	a_fail_no_pass: assert property (
		status.retryFail |-> !status.pass)
		else $error("failed device reported as pass");
	a_done_low_volts: assert property (
		$rose(status.done) |-> !pins.vppHigh && !pins.vccHigh)
		else $error("run ended with high voltages on");
	a_read_bus_free: assert property (
		!pins.oeLowN |-> !muxed_addr_data_lines_oe)
		else $error("controller drives the bus while the part outputs are on");
endmodule : otpps_seq_chk

bind otpps_sequencer otpps_seq_chk #(.AW(AW)) chk (.mclk(mclk), .rstn(rstn),
	.status(status), .pins(pins), .address_bit_eight(address_bit_eight),
	.muxed_addr_data_lines_oe(muxed_addr_data_lines_oe));

// file: testbench/otpps_dev_model.sv
// Behavioural memory part on the far side of the controller.
module otpps_dev_model #(
	parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value.
	parameter logic [7:0] KIND  = 8'hc3  // Arbitrary value.
) (
	input wire logic                   mclk,
	input wire logic                   rstn,
	input wire otpps_pkg::otpps_pins_t pins,
	input wire logic [7:0]             hiAddr,
	input wire logic [7:0]             busOut,
	input wire logic                   busOe,
	output logic [7:0]                 busIn
);
	import otpps_pkg::*;
	int          need   = 1;    // Pulses a cell takes before it holds data.
	bit          idMode = 0;    // Set by the bench for identification runs.
	logic [7:0]  mem [int];     // Programmed cells; blank reads as all ones.
	int          cnt [int];     // Pulses seen per address.
	logic [15:0] adr = 16'h0000;
	logic [7:0]  last = 8'h00;
	logic        rd;

	// Address latches on a falling strobe; a pulse lands on its falling edge.
	always @(negedge pins.latchStrobe or negedge rstn)
	begin
		if (!rstn)
		begin
			mem.delete();
			cnt.delete();
		end
		else if (!pins.vppHigh)
			adr = {hiAddr, busOut};
		else
		begin
			cnt[adr] = cnt.exists(adr) ? cnt[adr] + 1 : 1;
			if (cnt[adr] >= need)
				mem[adr] = busOut;
		end
	end

	assign rd = pins.vccOn && !busOe && !pins.vppHigh && !pins.oeLowN && !pins.latchStrobe;

	always @*
	begin
		if (rd && idMode)
			busIn = hiAddr[0] ? KIND : MAKER;
		else if (rd)
			busIn = mem.exists(adr) ? mem[adr] : 8'hff;
		else
			busIn = ~last;
	end

	// A released bus shows the inverse so stale data never passes.
	always @(posedge mclk)
		if (rd)
			last <= busIn;
endmodule : otpps_dev_model

// file: testbench/test_otp_program_verify_sequencer.sv
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

module test_otp_program_verify_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import otpps_pkg::*;
	logic          mclk = 0, rstn = 0, imgWrEn = 0, startProg = 0, startId = 0, busOe;
	logic [15:0]   imgWrAddr = 16'h0000, lastAddr = 16'h0001, idCodes;
	logic [7:0]    imgWrData = 8'h00, hiAddr, busIn, busOut;
	otpps_status_t status;
	otpps_pins_t   pins;
	int            err_total = 0, cmp_count = 0;

	// Full pulse length is kept so the window is tested; only gaps shrink.
	otpps_sequencer #(.PULSE_CYC(2500), .GAP_CYC(4)) uut (.mclk(mclk), .rstn(rstn), .imgWrEn(imgWrEn),
		.imgWrAddr(imgWrAddr), .imgWrData(imgWrData), .startProg(startProg), .startId(startId),
		.lastAddr(lastAddr), .status(status), .idCodes(idCodes), .pins(pins), .address_bit_eight(hiAddr),
		.muxed_addr_data_lines_in(busIn), .muxed_addr_data_lines_out(busOut), .muxed_addr_data_lines_oe(busOe));
	otpps_dev_model dev (.mclk(mclk), .rstn(rstn), .pins(pins), .hiAddr(hiAddr), .busOut(busOut),
		.busOe(busOe), .busIn(busIn));

	initial
		forever #10 mclk = ~mclk;

	// Resets both sides and loads a two-byte image.
	task automatic rst();
		rstn = 0;
		repeat (3) @(posedge mclk);
		#1 rstn = 1;
		for (int i = 0; i < 2; i++)
		begin
			@(posedge mclk) #1;
			imgWrEn = 1;
			imgWrAddr = 16'(i);
			imgWrData = i ? 8'ha5 : 8'h3c;
		end
		@(posedge mclk) #1 imgWrEn = 0;
	endtask : rst

	// One start pulse, then a bounded wait for the end of the run.
	task automatic run(input logic id, input int lim);
		int n = 0;
		@(posedge mclk) #1;
		startProg = !id;
		startId = id;
		@(posedge mclk) #1;
		startProg = 0;
		startId = 0;
		while (status.done !== 1'b1 && n < lim)
		begin
			@(posedge mclk) #1;
			n++;
		end
		`CHK(status.done, 1'b1)
		`CHK(status.busy, 1'b0)
	endtask : run

	task automatic t_ident();
		rst();
		dev.idMode = 1;
		run(1, 2000);
		`CHK(idCodes, {8'h5a, 8'hc3})
		$display("ident test ended");
	endtask : t_ident

	task automatic t_prog();
		rst();
		dev.idMode = 0;
		dev.need = 1;
		run(0, 12000);
		`CHK(status.pass, 1'b1)
		`CHK(status.retryFail, 1'b0)
		`CHK(dev.mem[0], 8'h3c)
		`CHK(dev.mem[1], 8'ha5)
		`CHK(dev.cnt[0], 1)
		$display("program test ended");
	endtask : t_prog

	// A cell that never takes its data must stop the run at that address.
	task automatic t_fail();
		rst();
		dev.need = 100;
		run(0, 36000);
		`CHK(status.retryFail, 1'b1)
		`CHK(status.pass, 1'b0)
		`CHK(status.failAddr, 16'h0000)
		`CHK(dev.cnt[0], 11)
		`CHK(dev.cnt[1], 1)
		$display("retry test ended");
	endtask : t_fail

	task stop_test();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	initial
	begin
		t_ident();
		t_prog();
		t_fail();
		stop_test();
	end

	// Runs need about 36000 cycles in all; beyond 60000 the design hung.
	initial
	begin
		repeat (60000) @(posedge mclk);
		err_total++;
		stop_test();
	end
endmodule : test_otp_program_verify_sequencer
